/* File: logic/och_top.sv */
`timescale 1ns/10ps
// Operation
// - overcurrent result is only looked at while the high-side drive is on
// - overcurrent during on-time ends the high-side pulse three mclk edges after oc_cmp rises, one edge more at a cycle start
// - a cut pulse stays off until the next switching cycle starts
// - each cycle with an overcurrent-cut pulse adds one to the fault count
// - each cycle finishing without overcurrent subtracts one from a nonzero fault count
// - count reaching seven issues restart and starts hiccup of seven soft-starts
// - both switch drives are off throughout the hiccup
// - hiccup decrements the count once per finished soft-start cycle
// - count back at zero re-enables switching with a normal start-up
// - persistent overcurrent counts seven pulses again and re-enters hiccup
// - switching cycles align to falling edges of the external sync clock
// - active sync clock replaces the internal oscillator
// - sync held low means free run from the internal oscillator
// - soft-start is held in reset while input supply is undervoltage
module och_top
    import och_pkg::*;
#(
    parameter logic [OSC_W-1:0] OSC_PERIOD = OSC_PERIOD_DEF
)
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic ce,
    // analog indications
    input  wire logic oc_cmp,
    input  wire logic ss_done,
    input  wire logic uvlo,
    input  wire logic sync_pin,
    // pwm request from the modulator
    input  wire logic pwm_req,
    // outputs
    output      logic hs_drv,
    output      logic ls_drv,
    output      logic ss_reset,
    output      logic restart,
    output      logic hiccup,
    output      logic [FCNT_W-1:0] fault_count
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sr_q;
    logic       rst_int_b;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            rst_sr_q <= 2'h0;
        else
            rst_sr_q <= {rst_sr_q[0], 1'b1};
    end
    assign rst_int_b = rst_sr_q[1];

    // ------------------------------------------------------------
    // clock selection
    // ------------------------------------------------------------
    logic cyc;

    och_clk_sel u_sel (
        .mclk        (mclk),
        .rst_b       (rst_int_b),
        .ce          (ce),
        .sync_pin    (sync_pin),
        .osc_period  (OSC_PERIOD),
        .cycle_start (cyc)
    );

    // ------------------------------------------------------------
    // protection state
    // ------------------------------------------------------------
    och_state_t st_q;
    och_state_t st_d;
    logic       oc_s;
    logic       ssd_s;
    logic       uv_s;
    logic       ssd_rise;

    // in_sr1 is the first stage, read only by in_sr2
    assign oc_s     = st_q.in_sr2[0];
    assign ssd_s    = st_q.in_sr2[1];
    assign uv_s     = st_q.in_sr2[2];
    assign ssd_rise = ssd_s & ~st_q.ss_rst & ~st_q.cut;

    always_comb begin
        st_d         = st_q;
        st_d.in_sr1  = {uvlo, ss_done, oc_cmp};
        st_d.in_sr2  = st_q.in_sr1;
        st_d.restart = 1'b0;
        // cut reused in hiccup as "soft-start already counted" latch
        unique case (st_q.mode)
            OCH_RUN: begin
                if (cyc) begin
                    if (st_q.oc_seen)
                        st_d.fcnt = st_q.fcnt + FCNT_ONE;
                    else if (st_q.fcnt != FCNT_ZERO)
                        st_d.fcnt = st_q.fcnt - FCNT_ONE;
                    st_d.oc_seen   = 1'b0;
                    st_d.cut       = 1'b0;
                    st_d.drv.hs_on = pwm_req;
                    st_d.drv.ls_on = ~pwm_req;
                end else begin
                    if (st_q.drv.hs_on && oc_s) begin
                        st_d.drv.hs_on = 1'b0;
                        st_d.drv.ls_on = 1'b1;
                        st_d.cut       = 1'b1;
                        st_d.oc_seen   = 1'b1;
                    end else if (!st_q.cut) begin
                        st_d.drv.hs_on = pwm_req;
                        st_d.drv.ls_on = ~pwm_req;
                    end
                end
                if (st_d.fcnt == FCNT_TRIP) begin
                    st_d.mode    = OCH_HICCUP;
                    st_d.restart = 1'b1;
                    st_d.drv     = '0;
                    st_d.ss_rst  = 1'b1;
                    st_d.cut     = 1'b0;
                    st_d.oc_seen = 1'b0;
                end
            end
            OCH_HICCUP: begin
                st_d.drv    = '0;
                st_d.ss_rst = 1'b0;
                if (ssd_rise) begin
                    st_d.fcnt   = st_q.fcnt - FCNT_ONE;
                    st_d.ss_rst = 1'b1;
                    st_d.cut    = 1'b1;
                end else if (!ssd_s) begin
                    st_d.cut = 1'b0;
                end
                if (st_q.fcnt == FCNT_ZERO) begin
                    st_d.mode   = OCH_RUN;
                    st_d.ss_rst = 1'b1;
                    st_d.cut    = 1'b0;
                end
            end
            default: begin
                st_d.mode = OCH_RUN;
            end
        endcase
        if (st_q.mode == OCH_RUN && st_q.ss_rst)
            st_d.ss_rst = 1'b0;
        if (uv_s) begin
            st_d.ss_rst = 1'b1;
            if (st_q.mode == OCH_RUN)
                st_d.drv = '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_int_b) begin
        if (!rst_int_b)
            st_q <= '{mode: OCH_RUN, ss_rst: 1'b1, default: '0};
        else if (ce)
            st_q <= st_d;
    end

    // ------------------------------------------------------------
    // outputs, all straight from st_q
    // ------------------------------------------------------------
    assign hs_drv      = st_q.drv.hs_on;
    assign ls_drv      = st_q.drv.ls_on;
    assign ss_reset    = st_q.ss_rst;
    assign restart     = st_q.restart;
    assign hiccup      = (st_q.mode == OCH_HICCUP);
    assign fault_count = st_q.fcnt;
endmodule

/* File: logic/och_pkg.sv */
package och_pkg;
    // fault counter
    localparam int          FCNT_W        = 3;
    localparam logic [2:0]  FCNT_ZERO     = 3'h0;
    localparam logic [2:0]  FCNT_ONE      = 3'h1;
    localparam logic [2:0]  FCNT_TRIP     = 3'h7;
    localparam logic [2:0]  HICCUP_CYCLES = 3'h7;
    // internal oscillator period in mclk cycles (resistor-programmed rate)
    localparam int          OSC_W         = 16;
    localparam logic [15:0] OSC_PERIOD_DEF = 16'h03e8;
    localparam logic [15:0] OSC_ONE       = 16'h0001;

    typedef enum logic [1:0] {
        OCH_RUN,
        OCH_HICCUP
    } och_mode_t;

    typedef struct packed {
        logic hs_on;
        logic ls_on;
    } och_drive_t;

    typedef struct packed {
        logic [2:0] sync_sr;
        logic       sync_used;
    } och_sel_state_t;

    typedef struct packed {
        och_mode_t  mode;
        logic [2:0] fcnt;
        logic       oc_seen;
        logic       cut;
        logic       restart;
        och_drive_t drv;
        logic       ss_rst;
        logic [2:0] in_sr1;
        logic [2:0] in_sr2;
    } och_state_t;
endpackage

/* File: logic/och_clk_sel.sv */
`timescale 1ns/10ps
module och_clk_sel
    import och_pkg::*;
(
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_b,
    input  wire logic               ce,
    // sources
    input  wire logic               sync_pin,
    input  wire logic [OSC_W-1:0]   osc_period,
    // cycle start
    output      logic               cycle_start
);
    och_sel_state_t   s_q;
    och_sel_state_t   s_d;
    logic [OSC_W-1:0] osc_q;
    logic [OSC_W-1:0] osc_d;
    logic             start_q;
    logic             start_d;
    logic             fall;

    // sync_sr[0] and [1] form the synchroniser; only [1] and [2] feed the edge detector
    always_comb begin
        s_d         = s_q;
        s_d.sync_sr = {s_q.sync_sr[1:0], sync_pin};
        fall        = s_q.sync_sr[2] & ~s_q.sync_sr[1];
        if (s_q.sync_sr[1])
            s_d.sync_used = 1'b1;
        osc_d   = osc_q;
        start_d = 1'b0;
        if (fall) begin
            start_d       = 1'b1;
            osc_d         = '0;
            s_d.sync_used = 1'b1;
        end else if (osc_q >= osc_period - OSC_ONE) begin
            // free run only after a whole period of idle low sync; a running sync beats it by 20-30%
            // a sync that stops costs one period before free run resumes
            osc_d         = '0;
            s_d.sync_used = s_q.sync_sr[1];
            if (!s_q.sync_used && !s_q.sync_sr[1])
                start_d = 1'b1;
        end else begin
            osc_d = osc_q + OSC_ONE;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_q     <= '0;
            osc_q   <= '0;
            start_q <= 1'b0;
        end else if (ce) begin
            s_q     <= s_d;
            osc_q   <= osc_d;
            start_q <= start_d;
        end
    end

    assign cycle_start = start_q;
endmodule

/* File: verif/och_chk_assertions.sv */
`timescale 1ns/10ps
// ----
// checks on the top ports
// ----
module och_chk (
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire logic       ce,
    input wire logic       oc_cmp,
    input wire logic       ss_done,
    input wire logic       uvlo,
    input wire logic       hs_drv,
    input wire logic       ls_drv,
    input wire logic       ss_reset,
    input wire logic       restart,
    input wire logic       hiccup,
    input wire logic [2:0] fault_count
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_cut; hs_drv && oc_cmp && ce |-> ##[1:4] !hs_drv; endproperty
    a_cut: assert property (p_cut) else $error("pulse not cut");
    property p_step; 1'b1 |=> (fault_count - $past(fault_count)) inside {3'h0, 3'h1, 3'h7}; endproperty
    a_step: assert property (p_step) else $error("count jumped");
    property p_sat; fault_count == 3'h0 |=> fault_count != 3'h7; endproperty
    a_sat: assert property (p_sat) else $error("count wrapped");
    property p_trip; $rose(hiccup) |-> restart && fault_count == 3'h7; endproperty
    a_trip: assert property (p_trip) else $error("bad hiccup entry");
    property p_pulse; restart |=> !restart && hiccup; endproperty
    a_pulse: assert property (p_pulse) else $error("restart not a pulse");
    property p_off; hiccup |-> !hs_drv && !ls_drv; endproperty
    a_off: assert property (p_off) else $error("drive on in hiccup");
    property p_dec; hiccup && $past(hiccup) && $changed(fault_count) |-> fault_count == $past(fault_count) - 3'h1;
    endproperty
    a_dec: assert property (p_dec) else $error("bad hiccup step");
    property p_quiet; (hiccup && !ss_done)[*6] |=> $stable(fault_count); endproperty
    a_quiet: assert property (p_quiet) else $error("count moved idle");
    property p_exit; $fell(hiccup) |-> $past(fault_count) == 3'h0; endproperty
    a_exit: assert property (p_exit) else $error("early hiccup exit");
    property p_uv; (uvlo && ce)[*5] |-> ss_reset && !hs_drv; endproperty
    a_uv: assert property (p_uv) else $error("undervoltage not held");
endmodule

/* File: verif/och_load_model.sv */
`timescale 1ns/10ps
// ----
// switch and sync source model
// ----
module och_load_model #(
    parameter int SYNC_HALF = 8
)
(
    // clock
    input  wire logic mclk,
    // controls
    input  wire logic short_en,
    input  wire logic sync_en,
    input  wire logic hs_drv,
    // pins
    output      logic oc_cmp,
    output      logic sync_pin
);
    int ph = 0;
    // the switch drop is only seen while its gate is driven
    assign oc_cmp = short_en & hs_drv;
    // stands low when off; 16 against 20 clocks is 25% fast
    always @(negedge mclk) begin
        ph <= (ph == 2 * SYNC_HALF - 1 || !sync_en) ? 0 : ph + 1;
        sync_pin <= sync_en && (ph < SYNC_HALF);
    end
endmodule

/* File: verif/och_top_bench.sv */
`timescale 1ns/10ps
module och_top_bench;
    logic       mclk = 0, rst_b = 0, ce = 1, ss_done = 0, uvlo = 0, pwm_req = 1, short_en = 0, sync_en = 0;
    logic       oc_cmp, sync_pin, hs_drv, ls_drv, ss_reset, restart, hiccup;
    logic [2:0] fault_count;
    int         err_total = 0, samples_checked = 0, cyc = 0, c;
    always #2.5 mclk = ~mclk;
    och_top #(.OSC_PERIOD(16'h0014)) uut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .oc_cmp(oc_cmp),
        .ss_done(ss_done), .uvlo(uvlo), .sync_pin(sync_pin), .pwm_req(pwm_req), .hs_drv(hs_drv),
        .ls_drv(ls_drv), .ss_reset(ss_reset), .restart(restart), .hiccup(hiccup), .fault_count(fault_count));
    och_load_model #(.SYNC_HALF(8)) pm (.mclk(mclk), .short_en(short_en), .sync_en(sync_en),
        .hs_drv(hs_drv), .oc_cmp(oc_cmp), .sync_pin(sync_pin));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    localparam int W_HS  = 0;
    localparam int W_HIC = 1;
    localparam int W_SSR = 2;
    function automatic logic pick(input int sel);
        case (sel)
            W_HS:    return hs_drv;
            W_HIC:   return hiccup;
            default: return ss_reset;
        endcase
    endfunction
    // a wait that runs out is a failure, never a silent pass
    task automatic wt(input int sel, input logic v);
        for (int i = 0; i < 400 && pick(sel) !== v; i++) @(negedge mclk);
        if (pick(sel) !== v) begin
            err_total++;
            $display("mismatch wait_%0d expected %b seen %b", sel, v, pick(sel));
        end
    endtask
    task automatic t_uvlo;
        uvlo = 1'b1;
        repeat (10) @(negedge mclk);
        chk("uv_out", 8'h1, 8'({hs_drv, ls_drv, ss_reset}));
        uvlo = 1'b0;
        repeat (60) @(negedge mclk);
    endtask
    task automatic t_period(input logic [7:0] per);
        short_en = 1'b1;
        wt(W_HS, 1'b0);
        wt(W_HS, 1'b1);
        c = cyc;
        wt(W_HS, 1'b0);
        chk("cut_fast", 8'h1, 8'(cyc - c <= 5));
        wt(W_HS, 1'b1);
        chk("period", per, 8'(cyc - c));
        short_en = 1'b0;
        repeat (200) @(negedge mclk);
        chk("clean_cnt", 8'h0, 8'(fault_count));
    endtask
    task automatic t_hiccup;
        short_en = 1'b1;
        wt(W_HIC, 1'b1);
        chk("trip_cnt", 8'h7, 8'(fault_count));
        chk("trip_drv", 8'h0, 8'({hs_drv, ls_drv}));
        // a counted soft-start shows three edges after ss_done rises, the exit one edge later
        for (int k = 0; k < 7; k++) begin
            wt(W_SSR, 1'b0);
            ss_done = 1'b1;
            repeat (4) @(negedge mclk);
            chk("hic_cnt", 8'(6 - k), 8'(fault_count));
            if (k == 6)
                chk("hic_end", 8'h0, 8'(hiccup));
            repeat (2) @(negedge mclk);
            ss_done = 1'b0;
            repeat (6) @(negedge mclk);
        end
        wt(W_HIC, 1'b1);
        chk("reenter", 8'h1, 8'(hiccup));
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            summarize;
        end
    end
    initial begin
        repeat (8) @(negedge mclk);
        chk("rst_out", 8'h1, 8'({hs_drv, ls_drv, ss_reset}));
        rst_b = 1'b1;
        // the core leaves reset two edges later; inputs count from the third edge
        repeat (4) @(negedge mclk);
        t_uvlo;
        t_period(8'd20);
        sync_en = 1'b1;
        t_period(8'd16);
        sync_en = 1'b0;
        t_hiccup;
        summarize;
    end
endmodule
bind och_top och_chk chk_i (.mclk(mclk), .rst_b(rst_b), .ce(ce), .oc_cmp(oc_cmp), .ss_done(ss_done),
    .uvlo(uvlo), .hs_drv(hs_drv), .ls_drv(ls_drv), .ss_reset(ss_reset), .restart(restart),
    .hiccup(hiccup), .fault_count(fault_count));
